// >>> rtl/scm_pkg.sv
package scm_pkg;
    // operation select codes
    typedef enum logic [3:0] {
        SCM_OP_XOR      = 4'h0, // vec_bitwise_xor
        SCM_OP_ADD      = 4'h1,
        SCM_OP_MUL      = 4'h2,
        SCM_OP_MULL     = 4'h3, // vec_multiply_widening
        SCM_OP_COPY     = 4'h4, // vec_copy_register
        SCM_OP_SWAP     = 4'h5, // vec_swap_registers
        SCM_OP_REV16    = 4'h6, // reverse_in_halfword
        SCM_OP_REV32    = 4'h7, // reverse_in_word
        SCM_OP_REV64    = 4'h8, // reverse_in_doubleword
        SCM_OP_EXT      = 4'h9, // byte_extract_window
        SCM_OP_TRN      = 4'ha, // pairwise_transpose
        SCM_OP_ZIP      = 4'hb, // interleave_pair
        SCM_OP_UZP      = 4'hc, // deinterleave_pair
        SCM_OP_TBL_ZERO = 4'hd, // table_lookup_zeroing
        SCM_OP_TBL_KEEP = 4'he  // table_lookup_preserving
    } scm_op_t;

    // element size select
    typedef enum logic [1:0] {
        SCM_SZ_8  = 2'h0,
        SCM_SZ_16 = 2'h1,
        SCM_SZ_32 = 2'h2
    } scm_size_t;

    localparam int SCM_VEC_W = 128;
    localparam int SCM_NBYTES = 16;
    localparam int SCM_TBL_REGS_MAX = 4;
    // table lookup processes this many index bytes per cycle
    localparam int SCM_TBL_BYTES_PER_CYC = 4;
    localparam int SCM_TBL_CYCLES = SCM_NBYTES / SCM_TBL_BYTES_PER_CYC;
    localparam logic [127:0] SCM_RESET_VEC = 128'h0;

    typedef enum logic [2:0] {
        SCM_ST_IDLE = 3'b001,
        SCM_ST_TBL  = 3'b010,
        SCM_ST_DONE = 3'b100
    } scm_state_t;
endpackage

// >>> rtl/scm_tbl_engine.sv
// combinational lookup of four index bytes selected by slice
module scm_tbl_engine (
    scm_tbl_if.eng t // lookup request and answer
);
    import scm_pkg::*;

    logic [8:0] tbl_len;
    assign tbl_len = {3'b000, t.table_regs, 3'b000};

    genvar g;
    generate
        for (g = 0; g < SCM_TBL_BYTES_PER_CYC; g++) begin : g_lane
            logic [3:0] pos;
            logic [7:0] idx;
            assign pos = {t.slice, 2'(g)};
            assign idx = t.index_vec[pos*8 +: 8];
            always_comb begin
                if ({1'b0, idx} < tbl_len) begin
                    t.slice_result[g*8 +: 8] =
                        t.table_bytes[idx[4:0]*8 +: 8]; // RULE_16 RULE_17
                end else if (t.preserve) begin
                    t.slice_result[g*8 +: 8] =
                        t.old_vec[pos*8 +: 8]; // RULE_18
                end else begin
                    t.slice_result[g*8 +: 8] = 8'h00; // RULE_18
                end
            end
        end
    endgenerate
endmodule

// >>> rtl/scm_tbl_if.sv
// lookup request/answer between the top and its table engine
interface scm_tbl_if;
    logic [255:0] table_bytes;
    logic [2:0] table_regs;
    logic [127:0] index_vec;
    logic [127:0] old_vec;
    logic preserve;
    logic [1:0] slice;
    logic [31:0] slice_result;
    modport top (output table_bytes, table_regs, index_vec, old_vec,
                 preserve, slice, input slice_result);
    modport eng (input table_bytes, table_regs, index_vec, old_vec,
                 preserve, slice, output slice_result);
endinterface

// >>> rtl/scm_unit.sv
// Operation
// [RULE_01] polynomial sum is bitwise XOR with no carries
// [RULE_02] polynomial product: AND partial products combined by XOR
// [RULE_03] only multiply and widening multiply go carry-less on poly lanes
// [RULE_04] vector add always carries, even on polynomial data
// [RULE_05] carry-less 3 times 3 gives 5, not 9
// [RULE_06] copy moves a whole register; swap exchanges two registers
// [RULE_07] swapping the halves of a 128-bit register exchanges them
// [RULE_08] halfword reverse swaps bytes in every 16-bit container
// [RULE_09] word reverse reverses bytes or halfwords in every 32 bits
// [RULE_10] doubleword reverse reverses bytes, halfwords or words per 64 bits
// [RULE_11] extract takes top bytes of first then bottom of second
// [RULE_12] extract of one vector with itself is a byte rotation
// [RULE_13] transpose swaps 2x2 element pairs, both results updated
// [RULE_14] zip interleaves elements of two vectors, 8/16/32 bits
// [RULE_15] unzip is the exact inverse of zip
// [RULE_16] table is one to four 64-bit registers as one byte array
// [RULE_17] each index byte fetches a table byte into same position
// [RULE_18] out-of-range index gives zero, or keeps old byte when extending
// [RULE_19] poly lane bit n is coefficient of x to the n, 8 or 16 bits
// [RULE_20] decoder presents op, size, operands with valid; takes results
// [RULE_21] simple ops take one cycle; lookups take several, flag done
module scm_unit
    import scm_pkg::*;
(
    input wire logic clk, // 40 MHz clock
    input wire logic reset, // async, active high
    input wire logic req_valid, // operation presented
    input scm_pkg::scm_op_t req_op, // operation select
    input scm_pkg::scm_size_t req_size, // element size
    input wire logic req_poly, // lanes are polynomial typed
    input wire logic req_wide, // operands are 128-bit (else 64-bit)
    input wire logic [3:0] req_imm, // extract byte offset
    input wire logic [2:0] req_tbl_regs, // table register count 1..4
    input wire logic [127:0] src_a, // first operand / table low
    input wire logic [127:0] src_b, // second operand / table high
    input wire logic [127:0] src_d, // index vector / old destination
    output logic req_ready, // idle and able to take a request
    output logic res_valid, // one-cycle completion pulse
    output logic [127:0] res_a, // first result
    output logic [127:0] res_b // second result (swap/trn/zip/uzp/mull)
);
    import scm_pkg::*;

    typedef struct packed {
        scm_state_t state;
        logic ready;
        logic valid;
        logic [127:0] res_a;
        logic [127:0] res_b;
        logic [1:0] slice;
        logic [127:0] index;
        logic [127:0] old;
        logic preserve;
        logic [2:0] regs;
        logic [255:0] table_bytes;
    } scm_regs_t;

    scm_regs_t st_reg, st_next;
    scm_tbl_if tif();

    assign tif.table_bytes = st_reg.table_bytes;
    assign tif.table_regs = st_reg.regs;
    assign tif.index_vec = st_reg.index;
    assign tif.old_vec = st_reg.old;
    assign tif.preserve = st_reg.preserve;
    assign tif.slice = st_reg.slice;

    scm_tbl_engine u_eng (.t(tif));

    // carry-less multiply of two 16-bit lanes
    function automatic logic [31:0] clmul16(input logic [15:0] a,
                                            input logic [15:0] b);
        logic [31:0] acc;
        acc = 32'h0;
        for (int i = 0; i < 16; i++) begin
            acc = acc ^ ({16'h0, a & {16{b[i]}}} << i); // RULE_02 RULE_19
        end
        return acc;
    endfunction

    // element byte index within a reversed container
    function automatic int rev_src(input int k, input int cont,
                                   input int esz);
        int base;
        int off;
        base = (k / cont) * cont;
        off = k % cont;
        return base + (cont - esz) - (off / esz) * esz + (off % esz);
    endfunction

    function automatic int esize(input scm_size_t s);
        case (s)
            SCM_SZ_8: return 1;
            SCM_SZ_16: return 2;
            default: return 4;
        endcase
    endfunction

    logic [127:0] alu_a, alu_b;
    logic [255:0] cat;

    always_comb begin
        int e, n, nb, ne, j, m;
        logic [15:0] x, y;
        logic [31:0] p;
        e = esize(req_size);
        nb = req_wide ? 16 : 8;
        ne = nb / e;
        alu_a = 128'h0;
        alu_b = 128'h0;
        cat = 256'h0;
        x = 16'h0;
        y = 16'h0;
        p = 32'h0;
        n = 0;
        j = 0;
        m = 0;
        case (req_op)
            SCM_OP_XOR: begin
                alu_a = src_a ^ src_b; // RULE_01
            end
            SCM_OP_ADD: begin
                for (int k = 0; k < 16; k++) begin
                    if (req_size == SCM_SZ_8) begin
                        alu_a[k*8 +: 8] = src_a[k*8 +: 8]
                            + src_b[k*8 +: 8]; // RULE_04
                    end else if (req_size == SCM_SZ_16 && k < 8) begin
                        alu_a[k*16 +: 16] = src_a[k*16 +: 16]
                            + src_b[k*16 +: 16]; // RULE_04
                    end else if (k < 4) begin
                        alu_a[k*32 +: 32] = src_a[k*32 +: 32]
                            + src_b[k*32 +: 32];
                    end
                end
            end
            SCM_OP_MUL, SCM_OP_MULL: begin
                // widening writes lane products into a 256-bit pair
                for (int k = 0; k < 16; k++) begin
                    if (k < nb / ((req_size == SCM_SZ_8) ? 1 : 2)) begin
                        if (req_size == SCM_SZ_8) begin
                            x = {8'h0, src_a[k*8 +: 8]};
                            y = {8'h0, src_b[k*8 +: 8]};
                        end else begin
                            x = src_a[k*16 +: 16];
                            y = src_b[k*16 +: 16];
                        end
                        if (req_poly) begin
                            p = clmul16(x, y); // RULE_03 RULE_05
                        end else begin
                            p = x * y; // RULE_03
                        end
                        if (req_op == SCM_OP_MUL) begin
                            if (req_size == SCM_SZ_8) begin
                                cat[k*8 +: 8] = p[7:0];
                            end else begin
                                cat[k*16 +: 16] = p[15:0];
                            end
                        end else if (req_size == SCM_SZ_8) begin
                            cat[k*16 +: 16] = p[15:0];
                        end else begin
                            cat[k*32 +: 32] = p;
                        end
                    end
                end
                alu_a = cat[127:0];
                alu_b = cat[255:128];
            end
            SCM_OP_COPY: begin
                alu_a = src_a; // RULE_06
            end
            SCM_OP_SWAP: begin
                if (req_wide) begin
                    alu_a = src_b; // RULE_06
                    alu_b = src_a;
                end else begin
                    // a 64-bit swap of one register's halves
                    alu_a = {src_a[63:0], src_a[127:64]}; // RULE_07
                    alu_b = src_b;
                end
            end
            SCM_OP_REV16, SCM_OP_REV32, SCM_OP_REV64: begin
                n = (req_op == SCM_OP_REV16) ? 2
                  : (req_op == SCM_OP_REV32) ? 4 : 8;
                m = (e >= n) ? n : e;
                for (int k = 0; k < 16; k++) begin
                    if (k < nb) begin
                        j = rev_src(k, n, (e >= n) ? 1 : e);
                        if (e >= n) begin
                            j = k;
                        end
                        alu_a[k*8 +: 8] = src_a[j*8 +: 8]; // RULE_08 RULE_09 RULE_10
                    end
                end
            end
            SCM_OP_EXT: begin
                // bytes from offset upward of a, then low bytes of b
                cat = (req_wide ? {src_b, src_a}
                                : {128'h0, src_b[63:0], src_a[63:0]});
                for (int k = 0; k < 16; k++) begin
                    if (k < nb) begin
                        j = k + int'(req_imm);
                        alu_a[k*8 +: 8] = cat[j*8 +: 8]; // RULE_11 RULE_12
                    end
                end
            end
            SCM_OP_TRN: begin
                for (int k = 0; k < 16; k++) begin
                    if (k < nb) begin
                        j = (k / e) % 2;
                        if (j == 0) begin
                            alu_a[k*8 +: 8] = src_a[k*8 +: 8];
                            alu_b[k*8 +: 8] = src_a[(k+e)*8 +: 8]; // RULE_13
                        end else begin
                            alu_a[k*8 +: 8] = src_b[(k-e)*8 +: 8]; // RULE_13
                            alu_b[k*8 +: 8] = src_b[k*8 +: 8];
                        end
                    end
                end
            end
            SCM_OP_ZIP: begin
                // element i of result pair comes from a or b alternately
                for (int k = 0; k < 32; k++) begin
                    if (k < 2 * nb) begin
                        j = k / e;
                        m = (j / 2) * e + (k % e);
                        if (k < nb) begin
                            alu_a[k*8 +: 8] = (j % 2 == 0) ?
                                src_a[m*8 +: 8] : src_b[m*8 +: 8]; // RULE_14
                        end else begin
                            alu_b[(k-nb)*8 +: 8] = (j % 2 == 0) ?
                                src_a[m*8 +: 8] : src_b[m*8 +: 8]; // RULE_14
                        end
                    end
                end
            end
            SCM_OP_UZP: begin
                cat = req_wide ? {src_b, src_a}
                               : {128'h0, src_b[63:0], src_a[63:0]};
                for (int k = 0; k < 16; k++) begin
                    if (k < nb) begin
                        j = k / e;
                        m = (2 * j) * e + (k % e);
                        alu_a[k*8 +: 8] = cat[m*8 +: 8]; // RULE_15
                        alu_b[k*8 +: 8] = cat[(m+e)*8 +: 8]; // RULE_15
                    end
                end
            end
            default: begin
                alu_a = 128'h0;
            end
        endcase
    end

    always_comb begin
        st_next = st_reg;
        st_next.valid = 1'b0;
        case (st_reg.state)
            SCM_ST_IDLE: begin
                if (req_valid) begin // RULE_20
                    if (req_op == SCM_OP_TBL_ZERO ||
                        req_op == SCM_OP_TBL_KEEP) begin
                        st_next.state = SCM_ST_TBL; // RULE_21
                        st_next.ready = 1'b0;
                        st_next.table_bytes = {src_b, src_a}; // RULE_16
                        st_next.regs = (req_tbl_regs == 3'h0) ? 3'h1
                            : (req_tbl_regs > 3'h4) ? 3'h4 : req_tbl_regs;
                        st_next.index = req_wide ? src_d
                                                 : {64'h0, src_d[63:0]};
                        st_next.old = src_d;
                        st_next.preserve = (req_op == SCM_OP_TBL_KEEP);
                        st_next.slice = 2'h0;
                        st_next.res_a = 128'h0;
                        st_next.res_b = 128'h0;
                    end else begin
                        st_next.res_a = alu_a; // RULE_21
                        st_next.res_b = alu_b;
                        st_next.valid = 1'b1;
                    end
                end
            end
            SCM_ST_TBL: begin
                st_next.res_a[st_reg.slice*32 +: 32] = tif.slice_result;
                st_next.slice = st_reg.slice + 2'h1;
                if (st_reg.slice == 2'(SCM_TBL_CYCLES - 1)) begin
                    st_next.state = SCM_ST_DONE;
                end
            end
            SCM_ST_DONE: begin
                st_next.valid = 1'b1; // RULE_21
                st_next.ready = 1'b1;
                st_next.state = SCM_ST_IDLE;
            end
            default: begin
                st_next.state = SCM_ST_IDLE;
                st_next.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_reg <= '{state: SCM_ST_IDLE, ready: 1'b1, valid: 1'b0,
                        res_a: SCM_RESET_VEC, res_b: SCM_RESET_VEC,
                        slice: 2'h0, index: SCM_RESET_VEC,
                        old: SCM_RESET_VEC, preserve: 1'b0, regs: 3'h1,
                        table_bytes: 256'h0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign req_ready = st_reg.ready;
    assign res_valid = st_reg.valid;
    assign res_a = st_reg.res_a;
    assign res_b = st_reg.res_b;

    a_xor_sum: assert property (@(posedge clk) disable iff (reset) // RULE_01
        (req_ready && req_valid && req_op == SCM_OP_XOR)
        |=> res_valid && res_a == ($past(src_a) ^ $past(src_b)))
        else $error("xor sum wrong");
    a_clmul_check: assert property (@(posedge clk) // RULE_05
        disable iff (reset)
        (req_ready && req_valid && req_op == SCM_OP_MUL && req_poly &&
         req_size == SCM_SZ_8 && src_a[7:0] == 8'h03 &&
         src_b[7:0] == 8'h03) |=> res_a[7:0] == 8'h05)
        else $error("carry-less 3x3 not 5");
    a_add_carry: assert property (@(posedge clk) disable iff (reset) // RULE_04
        (req_ready && req_valid && req_op == SCM_OP_ADD && req_poly &&
         req_size == SCM_SZ_8 && src_a[7:0] == 8'h03 &&
         src_b[7:0] == 8'h03) |=> res_a[7:0] == 8'h06)
        else $error("add did not carry");
    a_copy_whole: assert property (@(posedge clk) disable iff (reset) // RULE_06
        (req_ready && req_valid && req_op == SCM_OP_COPY)
        |=> res_a == $past(src_a))
        else $error("copy mismatch");
    a_swap_halves: assert property (@(posedge clk) // RULE_07
        disable iff (reset)
        (req_ready && req_valid && req_op == SCM_OP_SWAP && !req_wide)
        |=> res_a[63:0] == $past(src_a[127:64]))
        else $error("half swap wrong");
    a_rev16_bytes: assert property (@(posedge clk) // RULE_08
        disable iff (reset)
        (req_ready && req_valid && req_op == SCM_OP_REV16 &&
         req_size == SCM_SZ_8) |=> res_a[15:0] ==
         {$past(src_a[7:0]), $past(src_a[15:8])})
        else $error("halfword reverse wrong");
    a_tbl_latency: assert property (@(posedge clk) // RULE_21
        disable iff (reset)
        (req_ready && req_valid && (req_op == SCM_OP_TBL_ZERO ||
         req_op == SCM_OP_TBL_KEEP)) |=> !res_valid [*5] ##1 res_valid)
        else $error("lookup latency not six cycles");
    a_busy_ready: assert property (@(posedge clk) disable iff (reset) // RULE_21
        st_reg.state != SCM_ST_IDLE |-> !req_ready)
        else $error("ready while busy");
    a_tbl_zero: assert property (@(posedge clk) disable iff (reset) // RULE_18
        (st_reg.state == SCM_ST_TBL && !st_reg.preserve &&
         st_reg.slice == 2'h0 && st_reg.index[7:0] >= 8'h20)
        |=> st_reg.res_a[7:0] == 8'h00)
        else $error("out of range not zeroed");
endmodule

// >>> testbench/scm_dec_model.sv
// issues one request at a time and collects the answer
module scm_dec_model
    import scm_pkg::*;
(
    input wire logic clk, // unit clock
    input wire logic req_ready, // unit idle
    input wire logic res_valid, // answer pulse
    input wire logic [127:0] res_a, // first result
    input wire logic [127:0] res_b, // second result
    output logic req_valid, // request strobe
    output scm_pkg::scm_op_t req_op, // operation
    output scm_pkg::scm_size_t req_size, // element size
    output logic req_poly, // polynomial lanes
    output logic req_wide, // 128-bit operands
    output logic [3:0] req_imm, // extract offset
    output logic [2:0] req_tbl_regs, // table registers
    output logic [127:0] src_a, // operand a
    output logic [127:0] src_b, // operand b
    output logic [127:0] src_d // index or old destination
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [127:0] got_a;
    logic [127:0] got_b;
    int lat;
    logic rdy1;

    initial begin
        req_valid = 1'b0;
        req_op = SCM_OP_XOR;
        req_size = SCM_SZ_8;
        {req_poly, req_wide, req_imm, req_tbl_regs} = 9'h0;
        {src_a, src_b, src_d} = 384'h0;
    end

    task automatic issue(input scm_op_t op, input scm_size_t sz,
                         input logic poly, input logic wide,
                         input logic [3:0] imm, input logic [2:0] regs,
                         input logic [127:0] a, input logic [127:0] b,
                         input logic [127:0] d);
        int n;
        @(negedge clk);
        req_valid = 1'b1;
        req_op = op;
        req_size = sz;
        req_poly = poly;
        req_wide = wide;
        req_imm = imm;
        req_tbl_regs = regs;
        src_a = a;
        src_b = b;
        src_d = d;
        n = 0;
        while (req_ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        n = 0;
        do begin
            @(negedge clk);
            // operands inverted once taken, so a late sample shows up
            if (n == 0) begin
                req_valid = 1'b0;
                rdy1 = req_ready;
                src_a = ~a;
                src_b = ~b;
                src_d = ~d;
            end
            n++;
        end while (res_valid !== 1'b1 && n < 20);
        lat = n;
        got_a = res_a;
        got_b = res_b;
    endtask
endmodule

// >>> testbench/tb_top.sv
module tb_top;
    import scm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic req_valid, req_poly, req_wide, req_ready, res_valid;
    scm_op_t req_op;
    scm_size_t req_size;
    logic [3:0] req_imm;
    logic [2:0] req_tbl_regs;
    logic [127:0] src_a, src_b, src_d, res_a, res_b;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;

    always #12.5 clk = ~clk;

    scm_unit scm_unit_inst (.clk(clk), .reset(reset),
        .req_valid(req_valid), .req_op(req_op), .req_size(req_size),
        .req_poly(req_poly), .req_wide(req_wide), .req_imm(req_imm),
        .req_tbl_regs(req_tbl_regs), .src_a(src_a), .src_b(src_b),
        .src_d(src_d), .req_ready(req_ready), .res_valid(res_valid),
        .res_a(res_a), .res_b(res_b));
    scm_dec_model scm_dec_model_inst (.clk(clk), .req_ready(req_ready),
        .res_valid(res_valid), .res_a(res_a), .res_b(res_b),
        .req_valid(req_valid), .req_op(req_op), .req_size(req_size),
        .req_poly(req_poly), .req_wide(req_wide), .req_imm(req_imm),
        .req_tbl_regs(req_tbl_regs), .src_a(src_a), .src_b(src_b),
        .src_d(src_d));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [127:0] seen,
                         input logic [127:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [127:0] cnt(input logic [7:0] base);
        for (int k = 0; k < 16; k++)
            cnt[8*k +: 8] = base + 8'(k);
    endfunction

    task automatic go(input scm_op_t op, input int sz, input logic poly,
                      input logic wide, input logic [127:0] a,
                      input logic [127:0] b);
        scm_dec_model_inst.issue(op, scm_size_t'(sz), poly, wide, 4'h0,
                                 3'h1, a, b, 128'h0);
        check("latency", 128'(scm_dec_model_inst.lat), 128'h1);
    endtask

    task automatic t_arith();
        go(SCM_OP_MUL, 0, 1'b1, 1'b1, {16{8'h03}}, {16{8'h03}});
        check("clmul8", scm_dec_model_inst.got_a, {16{8'h05}});
        go(SCM_OP_MUL, 0, 1'b0, 1'b1, {16{8'h03}}, {16{8'h03}});
        check("mul8", scm_dec_model_inst.got_a, {16{8'h09}});
        // bit 8 set checks coefficient order across the byte boundary
        go(SCM_OP_MUL, 1, 1'b1, 1'b1, {8{16'h0103}}, {8{16'h0003}});
        check("clmul16", scm_dec_model_inst.got_a,
              {8{16'h0305}});
        go(SCM_OP_MULL, 0, 1'b1, 1'b0, {16{8'h03}}, {16{8'h03}});
        check("clmull", scm_dec_model_inst.got_a, {8{16'h0005}});
        go(SCM_OP_XOR, 0, 1'b1, 1'b1, {16{8'h0f}}, {16{8'h01}});
        check("xor", scm_dec_model_inst.got_a, {16{8'h0e}});
        go(SCM_OP_ADD, 0, 1'b1, 1'b1, {16{8'h03}}, {16{8'h03}});
        check("add", scm_dec_model_inst.got_a, {16{8'h06}});
        $display("test arith finished");
    endtask

    task automatic t_move();
        logic [127:0] a;
        logic [127:0] b;
        a = cnt(8'h00);
        b = cnt(8'h40);
        go(SCM_OP_COPY, 0, 1'b0, 1'b1, a, b);
        check("copy", scm_dec_model_inst.got_a, a);
        go(SCM_OP_SWAP, 0, 1'b0, 1'b1, a, b);
        check("swap", {scm_dec_model_inst.got_a, scm_dec_model_inst.got_b},
              {b, a});
        go(SCM_OP_SWAP, 0, 1'b0, 1'b0, a, b);
        check("halves", scm_dec_model_inst.got_a,
              {a[63:0], a[127:64]});
        $display("test move finished");
    endtask

    task automatic t_rev();
        scm_op_t ops[6] = '{SCM_OP_REV16, SCM_OP_REV32, SCM_OP_REV32,
                            SCM_OP_REV64, SCM_OP_REV64, SCM_OP_REV64};
        int cb[6] = '{2, 4, 4, 8, 8, 8};
        int sz[6] = '{0, 0, 1, 0, 1, 2};
        logic [127:0] x;
        int e;
        for (int i = 0; i < 6; i++) begin
            e = 1 << sz[i];
            for (int k = 0; k < 16; k++)
                x[8*k +: 8] = 8'((k / cb[i]) * cb[i] + k % e
                    + (cb[i] / e - 1 - (k % cb[i]) / e) * e);
            go(ops[i], sz[i], 1'b0, 1'b1, cnt(8'h00), 128'h0);
            check("reverse", scm_dec_model_inst.got_a, x);
        end
        $display("test reverse finished");
    endtask

    task automatic t_ext();
        logic [255:0] w;
        w = {cnt(8'h80), cnt(8'h00)} >> 24;
        scm_dec_model_inst.issue(SCM_OP_EXT, SCM_SZ_8, 1'b0, 1'b1, 4'h3,
                                 3'h1, cnt(8'h00), cnt(8'h80), 128'h0);
        check("extract", scm_dec_model_inst.got_a, w[127:0]);
        w = {cnt(8'h20), cnt(8'h20)} >> 72;
        scm_dec_model_inst.issue(SCM_OP_EXT, SCM_SZ_8, 1'b0, 1'b1, 4'h9,
                                 3'h1, cnt(8'h20), cnt(8'h20), 128'h0);
        check("rotate", scm_dec_model_inst.got_a, w[127:0]);
        $display("test extract finished");
    endtask

    task automatic t_perm();
        logic [127:0] a, b, ta, tb, za, zb;
        logic [255:0] z;
        int e;
        a = cnt(8'h00);
        b = cnt(8'h80);
        for (int s = 0; s < 3; s++) begin
            e = 1 << s;
            for (int i = 0; i < 16 / e; i++)
                for (int j = 0; j < e; j++) begin
                    z[8*((2*i)*e+j) +: 8] = a[8*(i*e+j) +: 8];
                    z[8*((2*i+1)*e+j) +: 8] = b[8*(i*e+j) +: 8];
                    ta[8*(i*e+j) +: 8] = (i % 2 == 0) ?
                        a[8*(i*e+j) +: 8] : b[8*((i-1)*e+j) +: 8];
                    tb[8*(i*e+j) +: 8] = (i % 2 == 0) ?
                        a[8*((i+1)*e+j) +: 8] : b[8*(i*e+j) +: 8];
                end
            go(SCM_OP_TRN, s, 1'b0, 1'b1, a, b);
            check("trn_a", scm_dec_model_inst.got_a, ta);
            check("trn_b", scm_dec_model_inst.got_b, tb);
            go(SCM_OP_ZIP, s, 1'b0, 1'b1, a, b);
            za = scm_dec_model_inst.got_a;
            zb = scm_dec_model_inst.got_b;
            check("zip", {zb, za}, z);
            go(SCM_OP_UZP, s, 1'b0, 1'b1, za, zb);
            check("unzip", {scm_dec_model_inst.got_b,
                  scm_dec_model_inst.got_a}, {b, a});
        end
        $display("test permute finished");
    endtask

    task automatic t_tbl();
        logic [127:0] d, x;
        logic [255:0] t;
        d = {2{64'h0311_0807_0010_0fff}};
        t = {cnt(8'h90), cnt(8'h10)};
        for (int r = 1; r <= 4; r++)
            for (int keep = 0; keep < 2; keep++) begin
                for (int k = 0; k < 16; k++)
                    x[8*k +: 8] = (d[8*k +: 8] < 8 * r) ?
                        t[8*d[8*k +: 8] +: 8] :
                        (keep ? d[8*k +: 8] : 8'h00);
                scm_dec_model_inst.issue(keep ? SCM_OP_TBL_KEEP :
                    SCM_OP_TBL_ZERO, SCM_SZ_8, 1'b0, 1'b1, 4'h0, 3'(r),
                    t[127:0], t[255:128], d);
                check("lookup", scm_dec_model_inst.got_a, x);
                check("lookup_lat", 128'(scm_dec_model_inst.lat),
                      128'h6);
                check("busy", 128'(scm_dec_model_inst.rdy1),
                      128'h0);
            end
        $display("test lookup finished");
    endtask

    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        t_arith();
        t_move();
        t_rev();
        t_ext();
        t_perm();
        t_tbl();
        complete_run();
    end
endmodule
